// ==== bpm_far_side.sv ====
// Purpose: far-side model of terminal equipment and tributary circuitry
// Assumes: 800 ns link clock, launched off the system clock phase
// Notes: clocks stand still between frames; a released pin shows the inverse level
module bpm_far_side (
  // shared pin
  input  wire logic  pin_w,
  output logic       pin_o,
  output logic       pin_oe,
  // rest of add bus and clocks
  output logic [3:0] add_hi,
  output logic [2:0] add_lo,
  output logic       add_clk,
  output logic       port_clk,
  input  wire logic  port_clk_w
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    pin_o = 1'b0;
    pin_oe = 1'b0;
    add_hi = 4'h0;
    add_lo = 3'h0;
    add_clk = 1'b0;
    port_clk = 1'b0;
  end

  // all eight bits presented at once, held until the next call
  task automatic put_byte(input logic [7:0] b);
    pin_oe = 1'b1;
    pin_o = b[3];
    add_hi = b[7:4];
    add_lo = b[2:0];
  endtask : put_byte

  // bus held well across the falling edge
  task automatic telecom_send(input logic [7:0] b);
    #130 put_byte(b);
    #400 add_clk = 1'b1;
    #400 add_clk = 1'b0;
    #500 pin_oe = 1'b0;
  endtask : telecom_send

  // msb first; data moves after the falling edge, stable at the rising one
  task automatic ssi_send(input logic [7:0] b);
    pin_oe = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      #130 pin_o = b[i];
      #270 port_clk = 1'b1;
      #400 port_clk = 1'b0;
    end
    #400 pin_oe = 1'b0;
  endtask : ssi_send

  // idle sends zeros, so the first one seen is the msb
  task automatic ssi_recv(output logic [7:0] b);
    int n;
    pin_oe = 1'b0;
    n = 0;
    do
    begin
      @(posedge port_clk_w);
      n++;
    end
    while (pin_w !== 1'b1 && n < 40);
    b = 8'h01;
    repeat (7)
    begin
      @(posedge port_clk_w);
      b = {b[6:0], pin_w};
    end
  endtask : ssi_recv
endmodule : bpm_far_side

// ==== bpm_params.svh ====
// Purpose: named constants for the shared bit 3 pin mux
// Assumes: included by bare name after the package
// Notes: offsets are byte addresses on a 32-bit AXI4-Lite bus
`ifndef BPM_PARAMS_SVH
`define BPM_PARAMS_SVH
`define BPM_AW          8
`define BPM_DW          32
`define BPM_BYTE_W      8
`define BPM_FIFO_DEPTH  16
`define BPM_LVL_W       5
`define BPM_ADDR_CTRL   8'h00
`define BPM_ADDR_STATUS 8'h04
`define BPM_ADDR_DATA   8'h08
`define BPM_CTRL_RST    8'h00
`define BPM_CTRL_TBUS   0
`define BPM_CTRL_MODE_L 1
`define BPM_CTRL_MODE_H 2
`define BPM_CTRL_DROP   3
`define BPM_MODE_HDLC   2'h1
`define BPM_MODE_MAPPER 2'h2
`define BPM_ST_ROLE_H   2
`define BPM_ST_OVF      3
`define BPM_ST_LVL_L    4
`define BPM_ST_LVL_H    8
`define BPM_DATA_VLD    8
`define BPM_HALF_W      4
`define BPM_HDLC_HALF   4'h4
`define BPM_SSI_HALF    4'h4
`define BPM_BIT_LAST    3'h7
`define BPM_RESP_OKAY   2'h0
`define BPM_RESP_SLVERR 2'h2
`define BPM_SYNC_W      10
`endif

// ==== bpm_pin_mux.sv ====
// Purpose: channel 1 transmit bit 3 shared pin, role mux and capture/drive logic
// Assumes: SYS_CLK far faster than any link clock; RST synchronous, active high
// Notes: captured bytes and drop bytes pass one 16-word FIFO
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`include "bpm_params.svh"

module bpm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // fill level
  output logic [LVL_W-1:0]      level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      rd_q;
  logic             push;
  logic             pop;

  assign level     = LVL_W'(wr_q - rd_q);
  assign in_ready  = (wr_q - rd_q) != (PW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[PW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q[PW-1:0]] <= in_data;
    end
  end

  // flush drops everything left over from the previous role
  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : bpm_fifo

module bpm_pin_mux (
  // system
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST,
  // axi4-lite write
  input  wire logic [`BPM_AW-1:0]    AXI_AWADDR,
  input  wire logic                  AXI_AWVALID,
  output logic                       AXI_AWREADY,
  input  wire logic [`BPM_DW-1:0]    AXI_WDATA,
  input  wire logic [3:0]            AXI_WSTRB,
  input  wire logic                  AXI_WVALID,
  output logic                       AXI_WREADY,
  output logic [1:0]                 AXI_BRESP,
  output logic                       AXI_BVALID,
  input  wire logic                  AXI_BREADY,
  // axi4-lite read
  input  wire logic [`BPM_AW-1:0]    AXI_ARADDR,
  input  wire logic                  AXI_ARVALID,
  output logic                       AXI_ARREADY,
  output logic [`BPM_DW-1:0]         AXI_RDATA,
  output logic [1:0]                 AXI_RRESP,
  output logic                       AXI_RVALID,
  input  wire logic                  AXI_RREADY,
  // shared bit 3 pin
  input  wire logic                  SHARED_BIT3_I,
  output logic                       SHARED_BIT3_O,
  output logic                       SHARED_BIT3_OE,
  // remaining add bus bits
  input  wire logic [3:0]            TELECOM_ADD_DATA_HI,
  input  wire logic [2:0]            TELECOM_ADD_DATA_LO,
  input  wire logic                  TELECOM_ADD_CLOCK,
  // hdlc byte clock
  output logic                       HDLC_TX_BYTE_CLOCK,
  // slow port clock pin
  input  wire logic                  SLOW_PORT_CLOCK_I,
  output logic                       SLOW_PORT_CLOCK_O,
  output logic                       SLOW_PORT_CLOCK_OE,
  // current role
  output bpm_pkg::bpm_role_t         ROLE
);
  import bpm_pkg::*;

  function automatic bpm_sel_t bpm_decode(input logic [`BPM_AW-1:0] a);
    case (a)
      `BPM_ADDR_CTRL:   bpm_decode = BPM_SEL_CTRL;
      `BPM_ADDR_STATUS: bpm_decode = BPM_SEL_STATUS;
      `BPM_ADDR_DATA:   bpm_decode = BPM_SEL_DATA;
      default:          bpm_decode = BPM_SEL_NONE;
    endcase
  endfunction : bpm_decode

  logic [`BPM_SYNC_W-1:0] s1_q;
  logic [`BPM_SYNC_W-1:0] s2_q;
  logic                   tclk_old_q;
  logic                   sclk_old_q;
  logic [`BPM_BYTE_W-1:0] bus_s;
  logic                   tclk_fall;
  logic                   sclk_rise;
  logic [7:0]             ctrl_q;
  bpm_role_t              role_q;
  bpm_role_t              role_d;
  logic                   ovf_q;
  logic [`BPM_AW-1:0]     awaddr_q;
  logic [`BPM_DW-1:0]     wdata_q;
  logic [3:0]             wstrb_q;
  bpm_sel_t               wr_sel;
  bpm_sel_t               rd_sel;
  logic                   wr_go;
  logic                   ar_hs;
  logic                   rd_pop;
  logic [`BPM_HALF_W-1:0] div_q;
  logic                   div_end;
  logic [2:0]             bit_q;
  logic [`BPM_BYTE_W-1:0] sh_q;
  logic                   cap_valid_q;
  logic [`BPM_BYTE_W-1:0] cap_byte_q;
  logic                   is_drop;
  logic                   ser_load;
  logic                   f_in_valid;
  logic [`BPM_BYTE_W-1:0] f_in_data;
  logic                   f_in_ready;
  logic                   f_out_valid;
  logic                   f_out_ready;
  logic [`BPM_BYTE_W-1:0] f_out_data;
  logic [`BPM_LVL_W-1:0]  f_level;

  // two flops on every pin input; only s2_q is looked at
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      s1_q <= '0;
      s2_q <= '0;
      tclk_old_q <= 1'b0;
      sclk_old_q <= 1'b0;
    end
    else
    begin
      s1_q <= {SLOW_PORT_CLOCK_I, TELECOM_ADD_CLOCK, TELECOM_ADD_DATA_HI,
               SHARED_BIT3_I, TELECOM_ADD_DATA_LO};
      s2_q <= s1_q;
      tclk_old_q <= s2_q[8];
      sclk_old_q <= s2_q[9];
    end
  end

  assign bus_s     = s2_q[7:0];
  assign tclk_fall = tclk_old_q & ~s2_q[8];
  assign sclk_rise = ~sclk_old_q & s2_q[9];

  // role selection
  always_comb
  begin
    if (ctrl_q[`BPM_CTRL_TBUS])
    begin
      role_d = BPM_ROLE_TELECOM;
    end
    else
    begin
      case (ctrl_q[`BPM_CTRL_MODE_H:`BPM_CTRL_MODE_L])
        `BPM_MODE_HDLC:   role_d = BPM_ROLE_HDLC;
        `BPM_MODE_MAPPER: role_d = ctrl_q[`BPM_CTRL_DROP] ? BPM_ROLE_SSI_DROP
                                                          : BPM_ROLE_SSI_ADD;
        default:          role_d = BPM_ROLE_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      role_q <= BPM_ROLE_IDLE;
    end
    else
    begin
      role_q <= role_d;
    end
  end

  assign is_drop = role_q == BPM_ROLE_SSI_DROP;
  assign ROLE    = role_q;

  // axi write channel
  assign wr_sel = bpm_decode(awaddr_q);
  // a drop byte waits here while the fifo is full, stalling the master
  assign wr_go  = ~AXI_AWREADY & ~AXI_WREADY & ~AXI_BVALID &
                  ~(wr_sel == BPM_SEL_DATA & is_drop & ~f_in_ready);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      AXI_AWREADY <= 1'b1;
      AXI_WREADY  <= 1'b1;
      AXI_BVALID  <= 1'b0;
      AXI_BRESP   <= `BPM_RESP_OKAY;
      awaddr_q    <= '0;
      wdata_q     <= '0;
      wstrb_q     <= '0;
    end
    else
    begin
      if (AXI_AWVALID && AXI_AWREADY)
      begin
        AXI_AWREADY <= 1'b0;
        awaddr_q    <= AXI_AWADDR;
      end
      if (AXI_WVALID && AXI_WREADY)
      begin
        AXI_WREADY <= 1'b0;
        wdata_q    <= AXI_WDATA;
        wstrb_q    <= AXI_WSTRB;
      end
      if (wr_go)
      begin
        AXI_BVALID  <= 1'b1;
        AXI_BRESP   <= (wr_sel == BPM_SEL_NONE) ? `BPM_RESP_SLVERR : `BPM_RESP_OKAY;
        AXI_AWREADY <= 1'b1;
        AXI_WREADY  <= 1'b1;
      end
      if (AXI_BVALID && AXI_BREADY)
      begin
        AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ctrl_q <= `BPM_CTRL_RST;
    end
    else if (wr_go && wr_sel == BPM_SEL_CTRL && wstrb_q[0])
    begin
      ctrl_q <= wdata_q[7:0];
    end
  end

  // overflow: a new loss wins over a clearing write
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ovf_q <= 1'b0;
    end
    else if (cap_valid_q && !f_in_ready && !is_drop)
    begin
      ovf_q <= 1'b1;
    end
    else if (wr_go && wr_sel == BPM_SEL_STATUS && wdata_q[`BPM_ST_OVF])
    begin
      ovf_q <= 1'b0;
    end
  end

  // axi read channel
  assign rd_sel = bpm_decode(AXI_ARADDR);
  assign ar_hs  = AXI_ARVALID & AXI_ARREADY;
  assign rd_pop = ar_hs & (rd_sel == BPM_SEL_DATA) & ~is_drop & f_out_valid;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      AXI_ARREADY <= 1'b1;
      AXI_RVALID  <= 1'b0;
      AXI_RDATA   <= '0;
      AXI_RRESP   <= `BPM_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      AXI_ARREADY <= 1'b0;
      AXI_RVALID  <= 1'b1;
      AXI_RRESP   <= (rd_sel == BPM_SEL_NONE) ? `BPM_RESP_SLVERR : `BPM_RESP_OKAY;
      AXI_RDATA   <= '0;
      case (rd_sel)
        BPM_SEL_CTRL:
        begin
          AXI_RDATA[7:0] <= ctrl_q;
        end
        BPM_SEL_STATUS:
        begin
          AXI_RDATA[`BPM_ST_ROLE_H:0]               <= role_q;
          AXI_RDATA[`BPM_ST_OVF]                    <= ovf_q;
          AXI_RDATA[`BPM_ST_LVL_H:`BPM_ST_LVL_L]    <= f_level;
        end
        BPM_SEL_DATA:
        begin
          AXI_RDATA[`BPM_DATA_VLD]       <= rd_pop;
          AXI_RDATA[`BPM_BYTE_W-1:0]     <= rd_pop ? f_out_data : '0;
        end
        default:
        begin
          AXI_RDATA <= '0;
        end
      endcase
    end
    else if (AXI_RVALID && AXI_RREADY)
    begin
      AXI_RVALID  <= 1'b0;
      AXI_ARREADY <= 1'b1;
    end
  end

  // shared divider for the two clocks the device makes
  assign div_end = div_q == (is_drop ? `BPM_SSI_HALF : `BPM_HDLC_HALF);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST || role_q != role_d)
    begin
      div_q              <= '0;
      HDLC_TX_BYTE_CLOCK <= 1'b0;
      SLOW_PORT_CLOCK_O  <= 1'b0;
    end
    else if (role_q == BPM_ROLE_HDLC || is_drop)
    begin
      div_q <= div_end ? '0 : div_q + 1'b1;
      if (div_end)
      begin
        HDLC_TX_BYTE_CLOCK <= (role_q == BPM_ROLE_HDLC) & ~HDLC_TX_BYTE_CLOCK;
        SLOW_PORT_CLOCK_O  <= is_drop & ~SLOW_PORT_CLOCK_O;
      end
    end
  end

  // capture in the input roles, serial drive in the drop role
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || role_q != role_d)
    begin
      cap_valid_q <= 1'b0;
      cap_byte_q  <= '0;
      bit_q       <= '0;
      sh_q        <= '0;
      SHARED_BIT3_O <= 1'b0;
    end
    else
    begin
      cap_valid_q <= 1'b0;
      case (role_q)
        BPM_ROLE_TELECOM:
        begin
          if (tclk_fall)
          begin
            cap_valid_q <= 1'b1;
            cap_byte_q  <= bus_s;
          end
        end
        BPM_ROLE_HDLC:
        begin
          // rising edge of the byte clock is the toggle from low
          if (div_end && !HDLC_TX_BYTE_CLOCK)
          begin
            cap_valid_q <= 1'b1;
            cap_byte_q  <= bus_s;
          end
        end
        BPM_ROLE_SSI_ADD:
        begin
          if (sclk_rise)
          begin
            sh_q  <= {sh_q[6:0], bus_s[3]};
            bit_q <= bit_q + 1'b1;
            if (bit_q == `BPM_BIT_LAST)
            begin
              cap_valid_q <= 1'b1;
              cap_byte_q  <= {sh_q[6:0], bus_s[3]};
            end
          end
        end
        BPM_ROLE_SSI_DROP:
        begin
          // falling edge of the port clock is the toggle from high
          if (div_end && SLOW_PORT_CLOCK_O)
          begin
            if (bit_q != '0)
            begin
              SHARED_BIT3_O <= sh_q[7];
              sh_q          <= {sh_q[6:0], 1'b0};
              bit_q         <= bit_q - 1'b1;
            end
            else if (f_out_valid)
            begin
              SHARED_BIT3_O <= f_out_data[7];
              sh_q          <= {f_out_data[6:0], 1'b0};
              bit_q         <= `BPM_BIT_LAST;
            end
            else
            begin
              // underrun sends zeros rather than stale bits
              SHARED_BIT3_O <= 1'b0;
            end
          end
        end
        default:
        begin
          cap_valid_q <= 1'b0;
        end
      endcase
    end
  end

  assign ser_load = is_drop & div_end & SLOW_PORT_CLOCK_O & (bit_q == '0);

  // output enables: drive only while dropping
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      SHARED_BIT3_OE     <= 1'b0;
      SLOW_PORT_CLOCK_OE <= 1'b0;
    end
    else
    begin
      SHARED_BIT3_OE     <= role_d == BPM_ROLE_SSI_DROP;
      SLOW_PORT_CLOCK_OE <= role_d == BPM_ROLE_SSI_DROP;
    end
  end

  // fifo direction follows the role
  assign f_in_valid  = is_drop ? (wr_go & wr_sel == BPM_SEL_DATA) : cap_valid_q;
  assign f_in_data   = is_drop ? wdata_q[`BPM_BYTE_W-1:0] : cap_byte_q;
  assign f_out_ready = is_drop ? ser_load : rd_pop;

  bpm_fifo #(
    .WIDTH (`BPM_BYTE_W),
    .DEPTH (`BPM_FIFO_DEPTH),
    .LVL_W (`BPM_LVL_W)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst       (RST),
    .flush     (role_q != role_d),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );
endmodule : bpm_pin_mux

// ==== bpm_pin_mux_checker.sv ====
// Purpose: port checker for the bit 3 pin mux
// Assumes: role and pin outputs are registers on SYS_CLK
// Notes: outputs judged once the role has held two cycles, since they may lag it
module bpm_pin_mux_checker (
  // system
  input wire logic               SYS_CLK,
  input wire logic               RST,
  // pin outputs
  input wire logic               SHARED_BIT3_O,
  input wire logic               SHARED_BIT3_OE,
  input wire logic               HDLC_TX_BYTE_CLOCK,
  input wire logic               SLOW_PORT_CLOCK_O,
  input wire logic               SLOW_PORT_CLOCK_OE,
  input wire bpm_pkg::bpm_role_t ROLE
);
  timeunit 1ns;
  timeprecision 1ns;
  import bpm_pkg::*;
  bpm_role_t role_q;
  logic      in_drop;
  logic      was_drop;
  logic      in_hdlc;
  logic      was_hdlc;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  always_ff @(posedge SYS_CLK)
  begin
    role_q <= RST ? BPM_ROLE_IDLE : ROLE;
  end
  assign in_drop  = ROLE == BPM_ROLE_SSI_DROP;
  assign was_drop = role_q == BPM_ROLE_SSI_DROP;
  assign in_hdlc  = ROLE == BPM_ROLE_HDLC;
  assign was_hdlc = role_q == BPM_ROLE_HDLC;

  pin_drive_a: assert property (!in_drop && !was_drop |-> !SHARED_BIT3_OE)
    else $error("pin driven outside drop role");
  drop_drive_a: assert property (in_drop && was_drop |-> SHARED_BIT3_OE && SLOW_PORT_CLOCK_OE)
    else $error("drop role not driving");
  port_idle_a: assert property (!in_drop && !was_drop |-> !SLOW_PORT_CLOCK_O && !SLOW_PORT_CLOCK_OE)
    else $error("port clock active outside drop");
  hdlc_idle_a: assert property (!in_hdlc && !was_hdlc |-> !HDLC_TX_BYTE_CLOCK)
    else $error("byte clock outside hdlc role");
  hdlc_high_a: assert property ($rose(HDLC_TX_BYTE_CLOCK) |->
    (HDLC_TX_BYTE_CLOCK[*5] ##1 !HDLC_TX_BYTE_CLOCK) or ##[1:5] !in_hdlc)
    else $error("byte clock high phase wrong");
  hdlc_low_a: assert property ($fell(HDLC_TX_BYTE_CLOCK) && in_hdlc |->
    ((!HDLC_TX_BYTE_CLOCK)[*5] ##1 HDLC_TX_BYTE_CLOCK) or ##[1:5] !in_hdlc)
    else $error("byte clock low phase wrong");
  port_high_a: assert property ($rose(SLOW_PORT_CLOCK_O) |->
    (SLOW_PORT_CLOCK_O[*5] ##1 !SLOW_PORT_CLOCK_O) or ##[1:5] !in_drop)
    else $error("port clock high phase wrong");
  drop_edge_a: assert property (in_drop && was_drop && $changed(SHARED_BIT3_O)
    |-> $fell(SLOW_PORT_CLOCK_O))
    else $error("drop data moved off the falling edge");
endmodule : bpm_pin_mux_checker

// ==== bpm_pin_mux_tb.sv ====
// Purpose: self-checking bench for the bit 3 pin mux
// Assumes: far-side model makes the 800 ns link clocks
// Notes: bready and rready stay high, so each answer is taken at once
`include "bpm_params.svh"
module bpm_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bpm_pkg::*;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, dut_o, dut_oe, pin_o, pin_oe;
  logic        add_clk, hdlc_clk, pclk_o, pclk_oe, port_clk, pin_w, pclk_w;
  logic [7:0]  awaddr, araddr, rx;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  add_hi;
  logic [2:0]  add_lo;
  bpm_role_t   role;
  int          err_total, comparisons, cyc;

  assign pin_w  = dut_oe ? dut_o : (pin_oe ? pin_o : ~pin_o);
  assign pclk_w = pclk_oe ? pclk_o : port_clk;

  bpm_pin_mux dut (
    .SYS_CLK(clk), .RST(rst), .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid),
    .AXI_AWREADY(awready), .AXI_WDATA(wdata), .AXI_WSTRB(4'hf), .AXI_WVALID(wvalid),
    .AXI_WREADY(wready), .AXI_BRESP(bresp), .AXI_BVALID(bvalid), .AXI_BREADY(bready),
    .AXI_ARADDR(araddr), .AXI_ARVALID(arvalid), .AXI_ARREADY(arready),
    .AXI_RDATA(rdata), .AXI_RRESP(rresp), .AXI_RVALID(rvalid), .AXI_RREADY(rready),
    .SHARED_BIT3_I(pin_w), .SHARED_BIT3_O(dut_o), .SHARED_BIT3_OE(dut_oe),
    .TELECOM_ADD_DATA_HI(add_hi), .TELECOM_ADD_DATA_LO(add_lo),
    .TELECOM_ADD_CLOCK(add_clk), .HDLC_TX_BYTE_CLOCK(hdlc_clk),
    .SLOW_PORT_CLOCK_I(pclk_w), .SLOW_PORT_CLOCK_O(pclk_o),
    .SLOW_PORT_CLOCK_OE(pclk_oe), .ROLE(role)
  );
  bpm_far_side far (
    .pin_w(pin_w), .pin_o(pin_o), .pin_oe(pin_oe), .add_hi(add_hi), .add_lo(add_lo),
    .add_clk(add_clk), .port_clk(port_clk), .port_clk_w(pclk_w)
  );

  always #50 clk = ~clk;

  // whole run is near 700 cycles; the ceiling leaves ample room
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic t_roles();
    logic [7:0] ctl [9] = '{8'h00, 8'h01, 8'h03, 8'h0d, 8'h02, 8'h04, 8'h0c, 8'h06, 8'h08};
    bpm_role_t  ex [9] = '{BPM_ROLE_IDLE, BPM_ROLE_TELECOM, BPM_ROLE_TELECOM,
      BPM_ROLE_TELECOM, BPM_ROLE_HDLC, BPM_ROLE_SSI_ADD, BPM_ROLE_SSI_DROP,
      BPM_ROLE_IDLE, BPM_ROLE_IDLE};
    rd(`BPM_ADDR_CTRL);
    chk(d, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      wr(`BPM_ADDR_CTRL, {24'h0, ctl[i]});
      repeat (2) @(posedge clk);
      chk({29'h0, role}, {29'h0, ex[i]});
      rd(`BPM_ADDR_STATUS);
      chk(d[2:0], ex[i]);
      chk(dut_oe, ex[i] == BPM_ROLE_SSI_DROP);
    end
  endtask : t_roles

  task automatic t_bus_err();
    wr(8'h0c, 32'h1);
    chk(r, `BPM_RESP_SLVERR);
    rd(8'h0c);
    chk(r, `BPM_RESP_SLVERR);
    chk(d, 32'h0);
  endtask : t_bus_err

  // every bit, bit 3 included, differs between the two bytes
  task automatic t_telecom();
    wr(`BPM_ADDR_CTRL, 32'h3);
    far.telecom_send(8'ha5);
    far.telecom_send(8'h5a);
    rd(`BPM_ADDR_DATA);
    chk(d, 32'h1a5);
    rd(`BPM_ADDR_DATA);
    chk(d, 32'h15a);
    rd(`BPM_ADDR_DATA);
    chk(d[8], 1'b0);
  endtask : t_telecom

  task automatic t_fifo();
    for (int i = 0; i < 17; i++)
      far.telecom_send(8'h20 + i[7:0]);
    rd(`BPM_ADDR_STATUS);
    chk(d, 32'h109);
    wr(`BPM_ADDR_STATUS, 32'h8);
    rd(`BPM_ADDR_STATUS);
    chk(d, 32'h101);
    for (int i = 0; i < 16; i++)
    begin
      rd(`BPM_ADDR_DATA);
      chk(d, 32'h120 + i);
    end
    rd(`BPM_ADDR_STATUS);
    chk(d, 32'h001);
  endtask : t_fifo

  // the byte is set before the role starts, so every capture holds it
  task automatic t_hdlc();
    logic [7:0] hb [2] = '{8'h08, 8'hf7};
    foreach (hb[i])
    begin
      wr(`BPM_ADDR_CTRL, 32'h0);
      far.put_byte(hb[i]);
      wr(`BPM_ADDR_CTRL, 32'h2);
      repeat (30) @(posedge clk);
      rd(`BPM_ADDR_DATA);
      chk(d, {23'h0, 1'b1, hb[i]});
    end
  endtask : t_hdlc

  task automatic t_add();
    wr(`BPM_ADDR_CTRL, 32'h4);
    far.ssi_send(8'hc5);
    far.ssi_send(8'h3a);
    rd(`BPM_ADDR_DATA);
    chk(d, 32'h1c5);
    rd(`BPM_ADDR_DATA);
    chk(d, 32'h13a);
  endtask : t_add

  task automatic t_drop();
    wr(`BPM_ADDR_CTRL, 32'hc);
    fork
      far.ssi_recv(rx);
      wr(`BPM_ADDR_DATA, 32'h96);
    join
    chk(rx, 8'h96);
    chk({dut_oe, pclk_oe}, 2'h3);
  endtask : t_drop

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_roles();
    t_bus_err();
    t_telecom();
    t_fifo();
    t_hdlc();
    t_add();
    t_drop();
    wrap_up();
  end
endmodule : bpm_pin_mux_tb

bind bpm_pin_mux bpm_pin_mux_checker chk_u (
  .SYS_CLK(SYS_CLK), .RST(RST), .SHARED_BIT3_O(SHARED_BIT3_O),
  .SHARED_BIT3_OE(SHARED_BIT3_OE), .HDLC_TX_BYTE_CLOCK(HDLC_TX_BYTE_CLOCK),
  .SLOW_PORT_CLOCK_O(SLOW_PORT_CLOCK_O), .SLOW_PORT_CLOCK_OE(SLOW_PORT_CLOCK_OE),
  .ROLE(ROLE)
);

// ==== bpm_pkg.sv ====
// Purpose: types for the shared bit 3 pin mux
// Assumes: nothing beyond SystemVerilog
// Notes: role codes are visible on the ROLE port and status register
package bpm_pkg;
  typedef enum logic [2:0] {
    BPM_ROLE_IDLE,
    BPM_ROLE_TELECOM,
    BPM_ROLE_HDLC,
    BPM_ROLE_SSI_ADD,
    BPM_ROLE_SSI_DROP
  } bpm_role_t;
  typedef enum logic [1:0] {
    BPM_SEL_NONE,
    BPM_SEL_CTRL,
    BPM_SEL_STATUS,
    BPM_SEL_DATA
  } bpm_sel_t;
endpackage : bpm_pkg
